// ### common/smc_pkg.sv
// Purpose: Shared constants and types for the supply monitor control block
// Assumes: 200 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes: Register indices are word indices; byte address is four times the index
package smc_pkg;
	// Clock period in ns
	localparam int CLK_PERIOD_NS = 5;
	// Default start-up time after the battery rises, in ns
	localparam int T_STARTUP_NS = 1000000;
	// Byte address width of the register bus
	localparam int ADDR_W = 10;
	// Register indices
	localparam logic [7:0] IDX_CTRL = 8'h10;
	localparam logic [7:0] IDX_STAT = 8'h1B;
	localparam logic [7:0] IDX_EVT_STAT = 8'h20;
	localparam logic [7:0] IDX_EVT_CLR = 8'h21;
	localparam logic [7:0] IDX_EVT_EN = 8'h22;
	// Field positions
	localparam int THR_LSB = 0;
	localparam int AUX_LSB = 2;
	localparam int V1S_BIT = 0;
	localparam int SENSOR_SUPPLY_STATUS_LSB = 1;
	localparam int EVT_PO_BIT = 0;
	localparam int EVT_V1U_BIT = 1;
	// Auxiliary output configuration codes
	localparam logic [1:0] AUX_OFF = 2'h0;
	localparam logic [1:0] AUX_NORMAL = 2'h1;
	localparam logic [1:0] AUX_NSR = 2'h2;
	localparam logic [1:0] AUX_ALL = 2'h3;
	// Sensor supply status codes
	localparam logic [1:0] SENSOR_SUPPLY_STATUS_OK = 2'h0;
	localparam logic [1:0] SENSOR_SUPPLY_STATUS_UV = 2'h1;
	localparam logic [1:0] SENSOR_SUPPLY_STATUS_OV = 2'h2;
	localparam logic [1:0] SENSOR_SUPPLY_STATUS_DIS = 2'h3;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Operating mode reported by the mode controller
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_STANDBY,
		MODE_SLEEP,
		MODE_RESET,
		MODE_OVERTEMP
	} smc_mode_t;
endpackage

// ### common/smc_reg_if.sv
// Purpose: Register access carrier between bus slave and supply core
// Assumes: Single clock domain
// Notes: Read index and data are combinational, write strobe is one cycle
`timescale 1ns/1ps
interface smc_reg_if;
	logic wr_stb; // One-cycle write pulse
	logic [7:0] wr_idx; // Write word index
	logic [7:0] wr_data; // Low byte of write data
	logic wr_hit; // Write index is mapped
	logic [7:0] rd_idx; // Read word index
	logic [7:0] rd_data; // Read value
	logic rd_hit; // Read index is mapped
	modport slave (output wr_stb, wr_idx, wr_data, rd_idx, input wr_hit, rd_data, rd_hit);
	modport core (input wr_stb, wr_idx, wr_data, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface

// ### core/smc_sync2.sv
// Purpose: Two-stage synchroniser for asynchronous level inputs
// Assumes: Inputs are slow levels
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module smc_sync2 #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1; // Metastable stage
		logic [W-1:0] s2; // Stable stage
	} smc_sync_t;
	smc_sync_t r_q, r_d;
	// Shift both stages
	always_comb begin
		r_d.s1 = din;
		r_d.s2 = r_q.s1;
	end
	// Register state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end
	assign dout = r_q.s2;
endmodule // smc_sync2

// ### core/smc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the supply registers
// Assumes: One write and one read outstanding at most
// Notes: Unmapped indices answer SLVERR; only byte lane 0 carries data
`timescale 1ns/1ps
module smc_axil_slave (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [smc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [smc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	smc_reg_if.slave rif
);
	typedef struct packed {
		logic aw_full; // Write address held
		logic [7:0] aw_idx; // Held write index
		logic w_full; // Write data held
		logic [7:0] wbyte; // Held write byte
		logic wlane0; // Byte lane 0 enabled
		logic awready; // Address ready
		logic wready; // Data ready
		logic bvalid; // Write response valid
		logic [1:0] bresp; // Write response code
		logic arready; // Read address ready
		logic rvalid; // Read data valid
		logic [31:0] rdata; // Read data
		logic [1:0] rresp; // Read response code
	} smc_axi_t;
	smc_axi_t q, d;
	logic fire; // Both halves of a write present
	// Channel handshakes and response generation
	always_comb begin
		d = q;
		fire = q.aw_full && q.w_full && !q.bvalid;
		if (awvalid && q.awready) begin
			d.aw_full = 1'b1;
			d.aw_idx = awaddr[9:2];
		end
		if (wvalid && q.wready) begin
			d.w_full = 1'b1;
			d.wbyte = wdata[7:0];
			d.wlane0 = wstrb[0];
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (fire) begin
			d.bvalid = 1'b1;
			d.bresp = rif.wr_hit ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
		end
		d.awready = !d.aw_full;
		d.wready = !d.w_full;
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end
		if (arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rdata = {24'h00_0000, rif.rd_data};
			d.rresp = rif.rd_hit ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
		end
		d.arready = !d.rvalid;
	end
	// Register state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign rif.wr_stb = fire && q.wlane0;
	assign rif.wr_idx = q.aw_idx;
	assign rif.wr_data = q.wbyte;
	assign rif.rd_idx = araddr[9:2];
	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
endmodule // smc_axil_slave

// ### core/smc_supply_ctrl.sv
// Purpose: Supply supervision, power-up sequencing and auxiliary output gating
// Assumes: Comparator and strap inputs are asynchronous; sys_mode is on aclk
// Notes: HAS_SENSOR selects sensor supply variant, else high-voltage inhibit
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module smc_supply_ctrl #(
	parameter int STARTUP_NS = smc_pkg::T_STARTUP_NS,
	parameter bit HAS_SENSOR = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [smc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [smc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Analog comparator levels
	input wire logic battery_below_poff,
	input wire logic battery_above_pon,
	input wire logic v1_below_90,
	input wire logic v1_below_80,
	input wire logic v1_below_70,
	input wire logic v1_below_60,
	input wire logic sensor_supply_out_below_uv,
	input wire logic sensor_supply_out_above_ov,
	// Non-volatile start-up straps
	input wire logic [1:0] startup_threshold_nvm_bits,
	input wire logic aux_output_startup_bit,
	// Operating mode from the mode controller
	input wire smc_pkg::smc_mode_t sys_mode,
	// Results
	output logic off_mode,
	output logic reset_mode_req,
	output logic system_reset_req,
	output logic aux_output_on,
	output logic irq
);
	// Start-up delay in cycles, rounded up, never below one
	localparam int STARTUP_RAW = (STARTUP_NS + smc_pkg::CLK_PERIOD_NS - 1) / smc_pkg::CLK_PERIOD_NS;
	localparam int STARTUP_CYC = (STARTUP_RAW < 1) ? 1 : STARTUP_RAW;

	// Refuse settings the counter cannot serve
	if (STARTUP_NS < 0) begin : g_bad_startup
		$error("STARTUP_NS must not be negative");
	end

	// Power sequencing states
	typedef enum logic [1:0] {
		ST_OFF,
		ST_STARTUP,
		ST_ACTIVE
	} smc_state_t;

	// Whole block state
	typedef struct packed {
		smc_state_t state; // Sequencer state
		logic [31:0] cnt; // Start-up counter
		logic [1:0] thr; // Reset threshold select
		logic [1:0] aux_cfg; // Aux output configuration
		logic po; // Power-on event flag
		logic v1u; // Undervoltage warning event
		logic [1:0] en; // Event enable register
		logic v1s; // Regulator status bit
		logic [1:0] sensor_supply_status; // Sensor supply status
		logic aux_on; // Aux output drive
		logic rst_req; // System reset request
		logic leave_off; // One-cycle Reset mode request
		logic off; // Off mode indicator
		logic irq; // Interrupt level
	} smc_core_t;

	smc_core_t q, d;
	smc_reg_if rif ();

	// Synchronised inputs
	logic [10:0] raw_in; // Asynchronous bundle
	logic [10:0] syn; // After two flip-flops
	logic bat_poff; // Battery below power-off
	logic bat_pon; // Battery above power-on
	logic [3:0] v1_below; // Index equals threshold code
	logic vx_uv; // Sensor supply under
	logic vx_ov; // Sensor supply over
	logic [1:0] nvm_thr; // Start-up threshold straps
	logic nvm_aux; // Start-up aux strap

	assign raw_in = {aux_output_startup_bit, startup_threshold_nvm_bits, sensor_supply_out_above_ov,
		sensor_supply_out_below_uv, v1_below_60, v1_below_70, v1_below_80, v1_below_90,
		battery_above_pon, battery_below_poff};

	// Two-flop capture of every pin level
	smc_sync2 #(
		.W(11)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(raw_in),
		.dout(syn)
	);

	assign bat_poff = syn[0];
	assign bat_pon = syn[1];
	assign v1_below = syn[5:2];
	assign vx_uv = syn[6];
	assign vx_ov = syn[7];
	assign nvm_thr = syn[9:8];
	assign nvm_aux = syn[10];

	// Bus front end
	smc_axil_slave u_axi (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.rif(rif.slave)
	);

	// Aux output wanted by configuration and mode
	function automatic logic aux_wanted(input logic [1:0] cfg, input smc_pkg::smc_mode_t m);
		logic on;
		on = 1'b0;
		case (cfg)
			smc_pkg::AUX_OFF: on = 1'b0;
			smc_pkg::AUX_NORMAL: on = (m == smc_pkg::MODE_NORMAL);
			smc_pkg::AUX_NSR: on = (m == smc_pkg::MODE_NORMAL) || (m == smc_pkg::MODE_STANDBY)
				|| (m == smc_pkg::MODE_RESET);
			smc_pkg::AUX_ALL: on = (m == smc_pkg::MODE_NORMAL) || (m == smc_pkg::MODE_STANDBY)
				|| (m == smc_pkg::MODE_RESET) || (m == smc_pkg::MODE_SLEEP);
			default: on = 1'b0;
		endcase
		return on;
	endfunction

	// Read decode, reserved bits are zero
	always_comb begin
		rif.rd_data = 8'h00;
		rif.rd_hit = 1'b1;
		case (rif.rd_idx)
			smc_pkg::IDX_CTRL: begin
				rif.rd_data[smc_pkg::THR_LSB +: 2] = q.thr;
				rif.rd_data[smc_pkg::AUX_LSB +: 2] = q.aux_cfg;
			end
			smc_pkg::IDX_STAT: begin
				rif.rd_data[smc_pkg::V1S_BIT] = q.v1s;
				rif.rd_data[smc_pkg::SENSOR_SUPPLY_STATUS_LSB +: 2] = q.sensor_supply_status;
			end
			smc_pkg::IDX_EVT_STAT: begin
				rif.rd_data[smc_pkg::EVT_PO_BIT] = q.po;
				rif.rd_data[smc_pkg::EVT_V1U_BIT] = q.v1u;
			end
			smc_pkg::IDX_EVT_EN: begin
				rif.rd_data[1:0] = q.en;
			end
			smc_pkg::IDX_EVT_CLR: begin
				rif.rd_data = 8'h00;
			end
			default: begin
				rif.rd_hit = 1'b0;
			end
		endcase
	end

	// Write index decode
	always_comb begin
		case (rif.wr_idx)
			smc_pkg::IDX_CTRL, smc_pkg::IDX_STAT, smc_pkg::IDX_EVT_CLR,
			smc_pkg::IDX_EVT_EN: rif.wr_hit = 1'b1;
			default: rif.wr_hit = 1'b0;
		endcase
	end

	// Next-state logic for the whole block
	always_comb begin
		d = q;
		d.leave_off = 1'b0;

		// Power sequencing
		case (q.state)
			ST_OFF: begin
				d.cnt = 32'h0000_0000;
				if (bat_pon && !bat_poff) begin
					d.state = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				if (!bat_pon) begin
					d.state = ST_OFF; // Battery dropped again, restart wait
				end else if (q.cnt >= 32'(STARTUP_CYC - 1)) begin
					d.state = ST_ACTIVE;
					d.leave_off = 1'b1;
					d.thr = nvm_thr;
					d.aux_cfg = nvm_aux ? smc_pkg::AUX_ALL : smc_pkg::AUX_OFF;
				end else begin
					d.cnt = q.cnt + 32'h0000_0001;
				end
			end
			ST_ACTIVE: begin
				d.cnt = 32'h0000_0000;
			end
			default: begin
				d.state = ST_OFF;
			end
		endcase
		if (bat_poff) begin
			d.state = ST_OFF;
			d.cnt = 32'h0000_0000;
		end

		// Register writes, low byte only, reserved bits dropped
		if (rif.wr_stb) begin
			case (rif.wr_idx)
				smc_pkg::IDX_CTRL: begin
					d.thr = rif.wr_data[smc_pkg::THR_LSB +: 2];
					d.aux_cfg = rif.wr_data[smc_pkg::AUX_LSB +: 2];
				end
				smc_pkg::IDX_EVT_CLR: begin
					if (rif.wr_data[smc_pkg::EVT_PO_BIT]) begin
						d.po = 1'b0;
					end
					if (rif.wr_data[smc_pkg::EVT_V1U_BIT]) begin
						d.v1u = 1'b0;
					end
				end
				smc_pkg::IDX_EVT_EN: begin
					d.en = rif.wr_data[1:0];
				end
				default: begin
					d.en = q.en; // Status register ignores writes
				end
			endcase
		end

		// Event capture after clears so that a set wins
		if (d.leave_off) begin
			d.po = 1'b1;
		end
		if (q.state == ST_ACTIVE && v1_below[0] && !q.v1s && q.en[smc_pkg::EVT_V1U_BIT]) begin
			d.v1u = 1'b1;
		end

		// Regulator status
		d.v1s = (q.state == ST_ACTIVE) ? v1_below[0] : 1'b0;

		// Reset request on selected threshold; code is comparator index
		d.rst_req = (q.state == ST_ACTIVE) && v1_below[q.thr];

		// Aux output gating
		if (q.state != ST_ACTIVE) begin
			d.aux_on = 1'b0;
		end else if (sys_mode == smc_pkg::MODE_OVERTEMP) begin
			if (HAS_SENSOR) begin
				d.aux_on = 1'b0;
			end else begin
				d.aux_on = q.aux_on;
			end
		end else begin
			d.aux_on = aux_wanted(q.aux_cfg, sys_mode);
		end

		// Sensor supply status
		if (!HAS_SENSOR) begin
			d.sensor_supply_status = smc_pkg::SENSOR_SUPPLY_STATUS_OK;
		end else if (!d.aux_on) begin
			d.sensor_supply_status = smc_pkg::SENSOR_SUPPLY_STATUS_DIS;
		end else if (vx_uv) begin
			d.sensor_supply_status = smc_pkg::SENSOR_SUPPLY_STATUS_UV;
		end else if (vx_ov) begin
			d.sensor_supply_status = smc_pkg::SENSOR_SUPPLY_STATUS_OV;
		end else begin
			d.sensor_supply_status = smc_pkg::SENSOR_SUPPLY_STATUS_OK;
		end

		// Misc outputs
		d.off = (d.state == ST_OFF) || (d.state == ST_STARTUP);
		d.irq = |({d.v1u, d.po} & d.en);
	end

	// Register the whole state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.state <= ST_OFF;
			q.off <= 1'b1;
			q.sensor_supply_status <= HAS_SENSOR ? smc_pkg::SENSOR_SUPPLY_STATUS_DIS : smc_pkg::SENSOR_SUPPLY_STATUS_OK;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from flip-flops
	assign off_mode = q.off;
	assign reset_mode_req = q.leave_off;
	assign system_reset_req = q.rst_req;
	assign aux_output_on = q.aux_on;
	assign irq = q.irq;
endmodule // smc_supply_ctrl

// ### tb/smc_supply_asserts.sv
// Purpose: Port assertions for the supply monitor control block
// Assumes: Regulator comparators form a thermometer code
// Notes: Bound into every instance of the block
`timescale 1ns/1ps
module smc_supply_asserts #(
	parameter int STARTUP_NS = 50,
	parameter bit HAS_SENSOR = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic battery_below_poff,
	input wire logic battery_above_pon,
	input wire logic v1_below_90,
	input wire logic v1_below_60,
	input wire smc_pkg::smc_mode_t sys_mode,
	input wire logic off_mode,
	input wire logic reset_mode_req,
	input wire logic system_reset_req,
	input wire logic aux_output_on,
	input wire logic irq
);
	localparam int SCYC = (STARTUP_NS + 4) / 5; // Start-up wait in cycles
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_off_on_poff: assert property (battery_below_poff [*4] |=> off_mode)
		else $error("off mode missing after battery loss");
	a_leave_pulse: assert property ($fell(off_mode) |-> reset_mode_req)
		else $error("leaving off without reset mode request");
	a_pulse_single: assert property (reset_mode_req |=> !reset_mode_req)
		else $error("reset mode request longer than one cycle");
	// Pin seen two flops late, one more step to enter the wait
	a_startup_wait: assert property ($fell(off_mode) |-> $past(battery_above_pon, SCYC + 3)
		&& !$past(battery_below_poff, SCYC + 3))
		else $error("left off before the start-up wait");
	a_reset_low_v1: assert property ((v1_below_60 && !off_mode) [*4]
		|=> system_reset_req || off_mode)
		else $error("no system reset with regulator under all thresholds");
	a_no_reset_ok: assert property (!v1_below_90 [*4] |=> !system_reset_req)
		else $error("system reset with regulator in range");
	a_aux_off: assert property (off_mode [*2] |-> !aux_output_on)
		else $error("aux output on while off");
	a_sensor_supply_out_overtemp: assert property (
		(HAS_SENSOR && sys_mode == smc_pkg::MODE_OVERTEMP) [*4] |=> !aux_output_on)
		else $error("sensor supply on in overtemp");
	// Main scenarios reached
	c_leave: cover property (reset_mode_req);
	c_irq: cover property (irq);
	c_sysrst: cover property (system_reset_req);
	c_sleep_on: cover property (aux_output_on && sys_mode == smc_pkg::MODE_SLEEP);
endmodule // smc_supply_asserts
bind smc_supply_ctrl smc_supply_asserts #(.STARTUP_NS(STARTUP_NS), .HAS_SENSOR(HAS_SENSOR))
	u_chk (.aclk(aclk), .aresetn(aresetn), .battery_below_poff(battery_below_poff),
	.battery_above_pon(battery_above_pon), .v1_below_90(v1_below_90),
	.v1_below_60(v1_below_60), .sys_mode(sys_mode), .off_mode(off_mode),
	.reset_mode_req(reset_mode_req), .system_reset_req(system_reset_req),
	.aux_output_on(aux_output_on), .irq(irq));

// ### tb/smc_supply_model.sv
// Purpose: Regulator and sensor load model driving comparator levels
// Assumes: Ideal comparators, below means strictly under
// Notes: Sensor state 0 ok, 1 under, 2 over
`timescale 1ns/1ps
module smc_supply_model (
	input wire logic [6:0] v1_pct,
	input wire logic [1:0] sensor_supply_out_state,
	output logic v1_below_90,
	output logic v1_below_80,
	output logic v1_below_70,
	output logic v1_below_60,
	output logic sensor_supply_out_below_uv,
	output logic sensor_supply_out_above_ov
);
	// Lower thresholds trip only after the higher ones
	assign v1_below_90 = v1_pct < 7'h5A;
	assign v1_below_80 = v1_pct < 7'h50;
	assign v1_below_70 = v1_pct < 7'h46;
	assign v1_below_60 = v1_pct < 7'h3C;
	// Sensor load faults
	assign sensor_supply_out_below_uv = sensor_supply_out_state == 2'h1;
	assign sensor_supply_out_above_ov = sensor_supply_out_state == 2'h2;
endmodule // smc_supply_model

// ### tb/smc_supply_ctrl_bench.sv
// Purpose: Self-checking bench for the supply monitor control block
// Assumes: Both variants side by side, start-up shortened to ten cycles
// Notes: Regulator and sensor comparator levels come from the load model; battery levels are driven by the bench
`timescale 1ns/1ps
module smc_supply_ctrl_bench;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [9:0] awaddr, araddr; // Bus addresses
	logic [31:0] wdata, rdata, rd; // Bus data, last read
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp, startup_threshold_nvm_bits, sensor_supply_out_state;
	logic battery_below_poff, battery_above_pon, aux_output_startup_bit;
	logic v1_below_90, v1_below_80, v1_below_70, v1_below_60, sensor_supply_out_below_uv, sensor_supply_out_above_ov;
	logic [6:0] v1_pct; // Regulator level in percent
	smc_pkg::smc_mode_t sys_mode;
	logic off_mode, reset_mode_req, system_reset_req, aux_output_on, irq;
	logic aux_inh; // Inhibit variant output
	logic [31:0] rdata_inh; // Inhibit variant read data
	int n_fail, cmp_count, seed, i, j, k;
	smc_supply_ctrl #(.STARTUP_NS(50), .HAS_SENSOR(1'b1)) dut (.*);
	// Inhibit variant, same stimulus, runs in lock-step with the sensor variant
	smc_supply_ctrl #(.STARTUP_NS(50), .HAS_SENSOR(1'b0)) dut_inh (.*, .awready(), .wready(),
		.bresp(), .bvalid(), .arready(), .rdata(rdata_inh), .rresp(), .rvalid(), .off_mode(),
		.reset_mode_req(), .system_reset_req(), .aux_output_on(aux_inh), .irq());
	smc_supply_model model (.*);
	// Clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// Compare and count
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Verdict
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Bus write, address and data offered together
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			ad = ad | awready;
			dd = dd | wready;
			if (ad) awvalid <= 1'b0;
			if (dd) wvalid <= 1'b0;
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		rsp = bresp;
	endtask
	// Bus read
	task automatic rdr(input logic [9:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
		rsp = rresp;
	endtask
	// Reset threshold in percent
	function automatic logic [6:0] thr_of(input logic [1:0] c);
		return 7'h5A - 7'h0A * 7'(c);
	endfunction
	// Aux output expected per config and mode
	function automatic logic aux_of(input logic [1:0] c, input smc_pkg::smc_mode_t m);
		case (c)
			2'h0: return 1'b0;
			2'h1: return m == smc_pkg::MODE_NORMAL;
			2'h2: return m inside {smc_pkg::MODE_NORMAL, smc_pkg::MODE_STANDBY, smc_pkg::MODE_RESET};
			default: return m != smc_pkg::MODE_OVERTEMP;
		endcase
	endfunction
	// Battery loss, then power-up with random straps
	task automatic power_up();
		@(posedge aclk);
		startup_threshold_nvm_bits <= 2'($random(seed));
		aux_output_startup_bit <= 1'($random(seed));
		battery_below_poff <= 1'b1;
		battery_above_pon <= 1'b0;
		repeat (6) @(posedge aclk);
		chk({off_mode, aux_output_on}, 2'h2);
		battery_below_poff <= 1'b0;
		repeat (20) @(posedge aclk);
		chk(off_mode, 1'b1);
		battery_above_pon <= 1'b1;
		k = 0;
		while (!reset_mode_req && k < 100) begin
			@(posedge aclk);
			k++;
		end
		chk(reset_mode_req, 1'b1);
		rdr(10'h040);
		chk(rd, {aux_output_startup_bit ? 2'h3 : 2'h0, startup_threshold_nvm_bits});
		rdr(10'h080);
		chk(rd[0], 1'b1);
		$display("test power_up done");
	endtask
	// Watchdog
	initial begin
		#(5 * 20000);
		n_fail++;
		results();
	end
	// Main sequence
	initial begin
		seed = 32'hf9b1;
		n_fail = 0;
		cmp_count = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		battery_below_poff = 1'b1;
		battery_above_pon = 1'b1;
		{startup_threshold_nvm_bits, aux_output_startup_bit, sensor_supply_out_state} = '0;
		v1_pct = 7'h5F;
		sys_mode = smc_pkg::MODE_NORMAL;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		power_up();
		for (i = 0; i < 24; i++) begin
			k = (i < 4) ? i : $unsigned($random(seed)) % 4;
			wr(10'h040, 32'(k) | 32'h0000_0004);
			v1_pct <= (i < 4) ? thr_of(2'(i)) : 7'(50 + $unsigned($random(seed)) % 50);
			repeat (6) @(posedge aclk);
			chk(system_reset_req, v1_pct < thr_of(2'(k)));
			rdr(10'h06C);
			chk(rd, 32'(v1_pct < 7'h5A));
			chk(rdata_inh, 32'(v1_pct < 7'h5A));
		end
		v1_pct <= 7'h5F;
		$display("test thresholds done");
		for (i = 0; i < 20; i++) begin
			sensor_supply_out_state <= 2'($unsigned($random(seed)) % 3);
			wr(10'h040, 32'(i / 5) << 2);
			sys_mode <= smc_pkg::smc_mode_t'(i % 5);
			repeat (6) @(posedge aclk);
			k = aux_of(2'(i / 5), smc_pkg::smc_mode_t'(i % 5));
			chk(aux_output_on, k[0]);
			// Overtemp follows Reset mode here, so the inhibit pin keeps that level
			j = (i % 5 == 4) ? 3 : i % 5;
			chk(aux_inh, aux_of(2'(i / 5), smc_pkg::smc_mode_t'(j)));
			rdr(10'h06C);
			chk(rd, {k[0] ? sensor_supply_out_state : 2'h3, 1'b0});
			chk(rdata_inh, 32'h0);
		end
		sys_mode <= smc_pkg::MODE_NORMAL;
		sensor_supply_out_state <= 2'h0;
		$display("test aux done");
		wr(10'h040, 32'hFFFF_FFFF);
		rdr(10'h040);
		chk({rsp, rd}, 34'h0_0000_000F);
		wr(10'h06C, 32'h0000_00FF);
		rdr(10'h06C);
		chk({rsp, rd}, 34'h0);
		rdr(10'h3FC);
		chk({rsp, rd}, {smc_pkg::RESP_SLVERR, 32'h0});
		$display("test reserved done");
		wr(10'h088, 32'h0);
		wr(10'h084, 32'h0000_0003);
		v1_pct <= 7'h55;
		repeat (6) @(posedge aclk);
		rdr(10'h080);
		chk(rd, 32'h0);
		v1_pct <= 7'h5F;
		wr(10'h088, 32'h0000_0003);
		v1_pct <= 7'h55;
		repeat (6) @(posedge aclk);
		rdr(10'h080);
		chk({irq, rd}, 33'h1_0000_0002);
		wr(10'h088, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		wr(10'h088, 32'h0000_0003);
		wr(10'h084, 32'h0000_0002);
		rdr(10'h080);
		chk({irq, rd}, 33'h0);
		$display("test events done");
		power_up();
		results();
	end
endmodule // smc_supply_ctrl_bench
